// ---- pkg/arith_mon_pkg.sv ----
// constants shared by the saturation flag monitor and its clamp unit
package arith_mon_pkg;

   // ----------------------------------------------------------------
   // register map, byte offsets on the bus
   // ----------------------------------------------------------------
   localparam logic [7:0] GROUP_SEL_OFS   = 8'h00; // group-select word
   localparam logic [7:0] FLAG_WORD_OFS   = 8'h04; // diagnostic flag word
   localparam logic [7:0] FAULT_EN_OFS    = 8'h08; // fault-enable word
   localparam logic [7:0] WARN_EN_OFS     = 8'h0c; // warning-enable word
   localparam logic [7:0] IRQ_STATUS_OFS  = 8'h10; // sticky events, rd clr
   localparam logic [7:0] IRQ_MASK_OFS    = 8'h14; // interrupt mask
   localparam logic [7:0] REPORT_CODE_OFS = 8'h18; // active report code
   localparam logic [7:0] FAULT_CLEAR_OFS = 8'h1c; // write bit0 = clear
   localparam logic [7:0] TORQUE_LIM_OFS  = 8'h20; // torque magnitude lim

   // ----------------------------------------------------------------
   // group-select codes and group indices
   // ----------------------------------------------------------------
   localparam int          NGRP         = 5;
   localparam logic [15:0] CODE_SPD_REF = 16'h2909; // 10505
   localparam logic [15:0] CODE_FDBK    = 16'h290a; // 10506
   localparam logic [15:0] CODE_SPD_REG = 16'h290b; // 10507
   localparam logic [15:0] CODE_TORQUE  = 16'h290c; // 10508
   localparam logic [15:0] CODE_PTRIM   = 16'h290d; // 10509
   localparam int GRP_SPD_REF = 0;
   localparam int GRP_FDBK    = 1;
   localparam int GRP_SPD_REG = 2;
   localparam int GRP_TORQUE  = 3;
   localparam int GRP_PTRIM   = 4;

   // ----------------------------------------------------------------
   // flag bit positions inside each group word
   // ----------------------------------------------------------------
   localparam int REF1_POS_BIT = 0;
   localparam int REF1_NEG_BIT = 1;
   localparam int REF7_POS_BIT = 2;
   localparam int REF7_NEG_BIT = 3;
   localparam int TRIM_POS_BIT = 8;
   localparam int TRIM_NEG_BIT = 9;
   localparam int ENC_DIV_BIT  = 0;
   localparam int LOW1_DIV_BIT = 1;
   localparam int LOW2_DIV_BIT = 2;
   localparam int INT_ERR_BIT  = 0;
   localparam int INT_GAIN_BIT = 1;
   localparam int BUMPLESS_BIT = 2;
   localparam int DROOP_BIT    = 3;
   localparam int SPD_ERR_BIT  = 8;
   localparam int FF_ERR_BIT   = 9;
   localparam int SLAVE_PCT_BIT = 10;
   localparam int REF_TRIM_BIT  = 12;
   localparam int TQ_SUM_BIT    = 13;
   localparam int FLUX_DIV_BIT  = 14;
   localparam int PT_ERR_BIT   = 0;
   localparam int PT_BUMP_BIT  = 1;
   localparam int PT_INT_BIT   = 2;
   localparam int PT_OUT_BIT   = 3;

   // ----------------------------------------------------------------
   // reporting and number range
   // ----------------------------------------------------------------
   localparam int          REPORT_BIT  = 10;       // in fault/warn words
   localparam logic [15:0] FAULT_CODE  = 16'h0bf2; // 3058
   localparam logic [15:0] WARN_CODE   = 16'h0c12; // 3090
   localparam logic signed [15:0] SAT_POS   = 16'sh7fff; // +32767
   localparam logic signed [15:0] SAT_NEG   = 16'sh8001; // -32767
   localparam logic signed [31:0] WIDE_POS  = 32'sh00007fff;
   localparam logic signed [31:0] WIDE_NEG  = 32'shffff8001;
   localparam logic [15:0] TORQUE_LIM_RST   = 16'h7fff;
   localparam int          NSAT        = 4;  // clamped paths
   localparam int          IRQ_W       = 3;
   localparam int          IRQ_FAULT   = 0;
   localparam int          IRQ_WARN    = 1;
   localparam int          IRQ_SAT     = 2;
   localparam int          CLEAR_BIT   = 0;

endpackage : arith_mon_pkg

// ---- pkg/sat_if.sv ----
// carrier between the monitor and one saturating clamp unit
`timescale 1ns/1ns
`default_nettype none
interface sat_if;
   logic signed [31:0] raw;     // wide result before clamping
   logic signed [15:0] clamped; // 16-bit result, clamped
   logic               pos;     // positive overflow this cycle
   logic               neg;     // negative overflow this cycle
   modport unit (input raw, output clamped, output pos, output neg);
   modport user (output raw, input clamped, input pos, input neg);
endinterface : sat_if
`default_nettype wire

// ---- hw/sat_clamp.sv ----
// saturating clamp of a wide signed result to the 16-bit range
`timescale 1ns/1ns
`default_nettype none
module sat_clamp
   import arith_mon_pkg::*;
(
   sat_if.unit port
);
   // ----------------------------------------------------------------
   // clamp: substitute the extreme of the right sign, never wrap
   // ----------------------------------------------------------------
   always_comb begin
      port.pos     = 1'b0;
      port.neg     = 1'b0;
      port.clamped = port.raw[15:0];
      if (port.raw > WIDE_POS) begin
         port.clamped = SAT_POS;
         port.pos     = 1'b1;
      end else if (port.raw < WIDE_NEG) begin
         port.clamped = SAT_NEG;
         port.neg     = 1'b1;
      end
   end
endmodule : sat_clamp
`default_nettype wire

// ---- hw/arith_overflow_flag_monitor.sv ----
// sticky saturation flag monitor with ahb-lite register access
// Contract
// - flag word shows the selected group
// - one bit per condition, several may set
// - code 10505: ref1 scaling pos/neg bits 0,1
// - ref7 scaling pos/neg in bits 2,3
// - ramp plus trim pos/neg bits 8,9
// - overflow substitutes signed extreme, keeps running
// - code 10506: feedback divide flags bits 0-2
// - code 10507: regulator flags bits 0-3,8,9
// - code 10508: torque flags bits 10,12,13,14
// - torque clamped to 800% before limits
// - code 10509: process trim flags bits 0-3
// - flags sticky until fault clear
// - warning when fault bit clear, warn set
// - neither reported when both bits clear
// - fault whenever fault-enable bit 10 set
// - codes 3058 for fault, 3090 warning
// - signed 16-bit, clamp to +/-32767
`timescale 1ns/1ns
`default_nettype none
module arith_overflow_flag_monitor
   import arith_mon_pkg::*;
#(
   parameter int FLAG_W = 16   // width of a group flag word
)(
   input  wire  logic               hclk,
   input  wire  logic               hresetn,
   input  wire  logic               hsel,
   input  wire  logic [31:0]        haddr,
   input  wire  logic [1:0]         htrans,
   input  wire  logic               hwrite,
   input  wire  logic [2:0]         hsize,
   input  wire  logic [31:0]        hwdata,
   input  wire  logic               hready,
   output var   logic [31:0]        hrdata,
   output var   logic               hreadyout,
   output var   logic               hresp,
   input  wire  logic               calc_strobe,
   input  wire  logic signed [31:0] spd_ref1_prod,
   input  wire  logic signed [31:0] spd_ref7_prod,
   input  wire  logic signed [31:0] trim_sum,
   input  wire  logic signed [31:0] torque_ref_raw,
   input  wire  logic [2:0]         fdbk_div_ovf,
   input  wire  logic [5:0]         spd_reg_ovf,
   input  wire  logic [3:0]         torque_ovf,
   input  wire  logic [3:0]         ptrim_ovf,
   input  wire  logic               fault_clear_in,
   output var   logic signed [15:0] spd_ref1_out,
   output var   logic signed [15:0] spd_ref7_out,
   output var   logic signed [15:0] trimmed_ref_out,
   output var   logic signed [15:0] torque_ref_out,
   output var   logic               fault_out,
   output var   logic               warn_out,
   output var   logic               irq
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [FLAG_W-1:0] flag_mem [NGRP];  // sticky flags per group
   logic [FLAG_W-1:0] ev       [NGRP];  // new events this cycle
   logic [15:0] group_sel_reg;          // selected group code
   logic [15:0] fault_en_reg;           // fault-enable word
   logic [15:0] warn_en_reg;            // warning-enable word
   logic [15:0] torque_lim_reg;         // torque magnitude limit
   logic [IRQ_W-1:0] status_reg;        // sticky interrupt events
   logic [IRQ_W-1:0] mask_reg;          // interrupt mask
   logic [IRQ_W-1:0] status_ev;         // interrupt events now
   logic        wr_pend_reg;            // write data phase pending
   logic [7:0]  wr_addr_reg;            // address of pending write
   logic        addr_ph;                // accepted address phase
   logic        rd_status;              // read of status register
   logic        sw_clear;               // software fault clear
   logic        clr;                    // any fault clear
   logic        sat_any;                // any saturation this cycle
   logic        fault_ev;               // saturation reported as fault
   logic        warn_ev;                // saturation reported as warn
   logic signed [15:0] sat_val [NSAT];  // clamped results
   logic        sat_pos [NSAT];         // positive overflow flags
   logic        sat_neg [NSAT];         // negative overflow flags
   logic signed [31:0] raw_arr [NSAT];  // wide results in
   logic signed [15:0] tq_lim_pos;      // signed positive limit
   logic signed [15:0] tq_lim_neg;      // signed negative limit

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   // group index of a select code; valid low for unknown codes
   function automatic logic [3:0] grp_of(input logic [15:0] code);
      // upper bit is the valid flag, low bits the index
      if (code == CODE_SPD_REF)
         return {1'b1, 3'(GRP_SPD_REF)};
      else if (code == CODE_FDBK)
         return {1'b1, 3'(GRP_FDBK)};
      else if (code == CODE_SPD_REG)
         return {1'b1, 3'(GRP_SPD_REG)};
      else if (code == CODE_TORQUE)
         return {1'b1, 3'(GRP_TORQUE)};
      else if (code == CODE_PTRIM)
         return {1'b1, 3'(GRP_PTRIM)};
      else
         return 4'h0;
   endfunction : grp_of

   // flag word for the selected group
   function automatic logic [FLAG_W-1:0] sel_flags(input logic [15:0] c);
      logic [3:0] g;
      g = grp_of(c);
      if (!g[3])
         return '0;
      else
         return flag_mem[g[2:0]];
   endfunction : sel_flags

   // ----------------------------------------------------------------
   // clamp units
   // ----------------------------------------------------------------
   assign raw_arr[0] = spd_ref1_prod;
   assign raw_arr[1] = spd_ref7_prod;
   assign raw_arr[2] = trim_sum;
   assign raw_arr[3] = torque_ref_raw;

   sat_if sat_bus [NSAT] ();
   generate
      for (genvar i = 0; i < NSAT; i++) begin : g_sat
         assign sat_bus[i].raw = raw_arr[i];
         sat_clamp u_clamp (
            .port (sat_bus[i])
         );
         assign sat_val[i] = sat_bus[i].clamped;
         assign sat_pos[i] = sat_bus[i].pos;
         assign sat_neg[i] = sat_bus[i].neg;
      end
   endgenerate

   // ----------------------------------------------------------------
   // event mapping into group words
   // ----------------------------------------------------------------
   // one bit per condition
   always_comb begin
      for (int g = 0; g < NGRP; g++)
         ev[g] = '0;
      ev[GRP_SPD_REF][REF1_POS_BIT] = calc_strobe & sat_pos[0];
      ev[GRP_SPD_REF][REF1_NEG_BIT] = calc_strobe & sat_neg[0];
      ev[GRP_SPD_REF][REF7_POS_BIT] = calc_strobe & sat_pos[1];
      ev[GRP_SPD_REF][REF7_NEG_BIT] = calc_strobe & sat_neg[1];
      ev[GRP_SPD_REF][TRIM_POS_BIT] = calc_strobe & sat_pos[2];
      ev[GRP_SPD_REF][TRIM_NEG_BIT] = calc_strobe & sat_neg[2];
      ev[GRP_FDBK][ENC_DIV_BIT]  = fdbk_div_ovf[0];
      ev[GRP_FDBK][LOW1_DIV_BIT] = fdbk_div_ovf[1];
      ev[GRP_FDBK][LOW2_DIV_BIT] = fdbk_div_ovf[2];
      ev[GRP_SPD_REG][INT_ERR_BIT]  = spd_reg_ovf[0];
      ev[GRP_SPD_REG][INT_GAIN_BIT] = spd_reg_ovf[1];
      ev[GRP_SPD_REG][BUMPLESS_BIT] = spd_reg_ovf[2];
      ev[GRP_SPD_REG][DROOP_BIT]    = spd_reg_ovf[3];
      ev[GRP_SPD_REG][SPD_ERR_BIT]  = spd_reg_ovf[4];
      ev[GRP_SPD_REG][FF_ERR_BIT]   = spd_reg_ovf[5];
      ev[GRP_TORQUE][SLAVE_PCT_BIT] = torque_ovf[0];
      ev[GRP_TORQUE][REF_TRIM_BIT]  = torque_ovf[1];
      ev[GRP_TORQUE][TQ_SUM_BIT]    = torque_ovf[2];
      ev[GRP_TORQUE][FLUX_DIV_BIT]  = torque_ovf[3];
      ev[GRP_PTRIM][PT_ERR_BIT]  = ptrim_ovf[0];
      ev[GRP_PTRIM][PT_BUMP_BIT] = ptrim_ovf[1];
      ev[GRP_PTRIM][PT_INT_BIT]  = ptrim_ovf[2];
      ev[GRP_PTRIM][PT_OUT_BIT]  = ptrim_ovf[3];
   end

   always_comb begin
      sat_any = 1'b0;
      for (int g = 0; g < NGRP; g++)
         sat_any = sat_any | (|ev[g]);
   end

   assign fault_ev = sat_any & fault_en_reg[REPORT_BIT];
   assign warn_ev  = sat_any & ~fault_en_reg[REPORT_BIT]
                   & warn_en_reg[REPORT_BIT];
   assign status_ev = {sat_any, warn_ev, fault_ev};

   // ----------------------------------------------------------------
   // sticky flag storage
   // ----------------------------------------------------------------
   // a set in the clear cycle survives so no event is lost
   generate
      for (genvar g = 0; g < NGRP; g++) begin : g_flags
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               flag_mem[g] <= '0;
            else
               flag_mem[g] <= (clr ? '0 : flag_mem[g]) | ev[g];
         end
      end
   endgenerate

   // fault and warning indications, cleared with the flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_out <= 1'b0;
         warn_out  <= 1'b0;
      end else begin
         fault_out <= (clr ? 1'b0 : fault_out) | fault_ev;
         warn_out  <= (clr ? 1'b0 : warn_out) | warn_ev;
      end
   end

   // ----------------------------------------------------------------
   // clamped data outputs
   // ----------------------------------------------------------------
   assign tq_lim_pos = signed'(torque_lim_reg);
   assign tq_lim_neg = 16'sh0000 - tq_lim_pos;

   // results update once per control cycle strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         spd_ref1_out    <= 16'sh0000;
         spd_ref7_out    <= 16'sh0000;
         trimmed_ref_out <= 16'sh0000;
         torque_ref_out  <= 16'sh0000;
      end else if (calc_strobe) begin
         spd_ref1_out    <= sat_val[0];
         spd_ref7_out    <= sat_val[1];
         trimmed_ref_out <= sat_val[2];
         if (sat_val[3] > tq_lim_pos)
            torque_ref_out <= tq_lim_pos;
         else if (sat_val[3] < tq_lim_neg)
            torque_ref_out <= tq_lim_neg;
         else
            torque_ref_out <= sat_val[3];
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ----------------------------------------------------------------
   assign addr_ph   = hsel & hready & htrans[1];
   assign rd_status = addr_ph & ~hwrite & (haddr[7:0] == IRQ_STATUS_OFS);
   assign sw_clear  = wr_pend_reg & (wr_addr_reg == FAULT_CLEAR_OFS)
                    & hwdata[CLEAR_BIT];
   assign clr       = sw_clear | fault_clear_in;

   // bus answer is always ready and okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // write address captured for the following data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_ph & hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   // software-written control words
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         group_sel_reg  <= 16'h0000;
         fault_en_reg   <= 16'h0000;
         warn_en_reg    <= 16'h0000;
         mask_reg       <= 3'h0;
         torque_lim_reg <= TORQUE_LIM_RST;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == GROUP_SEL_OFS)
            group_sel_reg <= hwdata[15:0];
         else if (wr_addr_reg == FAULT_EN_OFS)
            fault_en_reg <= hwdata[15:0];
         else if (wr_addr_reg == WARN_EN_OFS)
            warn_en_reg <= hwdata[15:0];
         else if (wr_addr_reg == IRQ_MASK_OFS)
            mask_reg <= hwdata[IRQ_W-1:0];
         else if (wr_addr_reg == TORQUE_LIM_OFS)
            torque_lim_reg <= {1'b0, hwdata[14:0]};
      end
   end

   // read data latched at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ph & ~hwrite) begin
         if (haddr[7:0] == GROUP_SEL_OFS)
            hrdata <= {16'h0000, group_sel_reg};
         else if (haddr[7:0] == FLAG_WORD_OFS)
            hrdata <= {16'h0000, sel_flags(group_sel_reg)};
         else if (haddr[7:0] == FAULT_EN_OFS)
            hrdata <= {16'h0000, fault_en_reg};
         else if (haddr[7:0] == WARN_EN_OFS)
            hrdata <= {16'h0000, warn_en_reg};
         else if (haddr[7:0] == IRQ_STATUS_OFS)
            hrdata <= {29'h0, status_reg};
         else if (haddr[7:0] == IRQ_MASK_OFS)
            hrdata <= {29'h0, mask_reg};
         else if (haddr[7:0] == REPORT_CODE_OFS)
            hrdata <= {16'h0000, fault_out ? FAULT_CODE :
                                 warn_out  ? WARN_CODE : 16'h0000};
         else if (haddr[7:0] == TORQUE_LIM_OFS)
            hrdata <= {16'h0000, torque_lim_reg};
         else
            hrdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, read clears, set wins
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         status_reg <= 3'h0;
      else
         status_reg <= (rd_status ? 3'h0 : status_reg) | status_ev;
   end

   // level output one cycle behind the status bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(status_reg & mask_reg);
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_flag_read;
      addr_ph && !hwrite && haddr[7:0] == FLAG_WORD_OFS
      |=> hrdata[FLAG_W-1:0] == $past(sel_flags(group_sel_reg));
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag word read mismatch");

   property p_ref1_pos;
      calc_strobe && spd_ref1_prod > WIDE_POS
      |=> flag_mem[GRP_SPD_REF][REF1_POS_BIT]
          && spd_ref1_out == SAT_POS;
   endproperty
   a_ref1_pos: assert property (p_ref1_pos)
      else $error("ref1 positive overflow not caught");

   property p_trim_neg;
      calc_strobe && trim_sum < WIDE_NEG
      |=> flag_mem[GRP_SPD_REF][TRIM_NEG_BIT]
          && trimmed_ref_out == SAT_NEG;
   endproperty
   a_trim_neg: assert property (p_trim_neg)
      else $error("trim negative overflow not caught");

   property p_torque_lim;
      calc_strobe |=> torque_ref_out <= tq_lim_pos
                      && torque_ref_out >= tq_lim_neg;
   endproperty
   a_torque_lim: assert property (p_torque_lim)
      else $error("torque reference beyond limit");

   property p_clear;
      clr && !sat_any |=> flag_mem[GRP_FDBK] == '0
                          && flag_mem[GRP_PTRIM] == '0 && !fault_out;
   endproperty
   a_clear: assert property (p_clear)
      else $error("fault clear left flags set");

   property p_sticky;
      flag_mem[GRP_SPD_REG] != '0 && !clr
      |=> flag_mem[GRP_SPD_REG] != '0;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without clear");

   property p_warn;
      sat_any && !fault_en_reg[REPORT_BIT] && warn_en_reg[REPORT_BIT]
      |=> warn_out && !$rose(fault_out);
   endproperty
   a_warn: assert property (p_warn)
      else $error("warning not raised");

   property p_silent;
      !fault_out && !fault_en_reg[REPORT_BIT] |=> !fault_out;
   endproperty
   a_silent: assert property (p_silent)
      else $error("fault raised while disabled");

   property p_fault;
      sat_any && fault_en_reg[REPORT_BIT] |=> fault_out ##1 irq
                                            || !mask_reg[IRQ_FAULT];
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault not raised");

   property p_code;
      addr_ph && !hwrite && haddr[7:0] == REPORT_CODE_OFS && fault_out
      |=> hrdata[15:0] == FAULT_CODE;
   endproperty
   a_code: assert property (p_code)
      else $error("wrong fault code");

   c_fault: cover property (fault_ev ##1 fault_out);
   c_warn: cover property (warn_ev ##2 irq);
   c_clear: cover property (fault_out ##1 clr ##1 !fault_out);
endmodule : arith_overflow_flag_monitor
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the saturation flag monitor
`timescale 1ns/1ns
`default_nettype none
`define chk(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
   failures++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top
   import arith_mon_pkg::*;
;
   logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
   logic               hwrite = 1'b0, calc_strobe = 1'b0, fclr = 1'b0;
   logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]         htrans = 2'h0;
   logic signed [31:0] p1 = 32'sh0, p7 = 32'sh0, ts = 32'sh0, tq = 32'sh0;
   logic [2:0]         fd = 3'h0;
   logic [5:0]         sr = 6'h0;
   logic [3:0]         to = 4'h0, pt = 4'h0;
   logic               hreadyout, hresp, fault_out, warn_out, irq;
   logic signed [15:0] o1, o7, ot, oq;
   int                 failures = 0, total_checks = 0;
   always #50 hclk = ~hclk; // 10 MHz
   arith_overflow_flag_monitor u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .calc_strobe(calc_strobe),
      .spd_ref1_prod(p1), .spd_ref7_prod(p7), .trim_sum(ts),
      .torque_ref_raw(tq), .fdbk_div_ovf(fd), .spd_reg_ovf(sr),
      .torque_ovf(to), .ptrim_ovf(pt), .fault_clear_in(fclr),
      .spd_ref1_out(o1), .spd_ref7_out(o7), .trimmed_ref_out(ot),
      .torque_ref_out(oq), .fault_out(fault_out), .warn_out(warn_out),
      .irq(irq));
   task summarize;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   // bounded wait for hready; a stuck bus ends the run
   task automatic wt;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         if (++n > 50) begin failures++; summarize; end
         @(posedge hclk);
      end
   endtask : wt
   // one single ahb-lite transfer, address phase then data phase
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      wt;
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      wt;
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      `chk("rd", e, q)
      `chk("resp", 1'b0, hresp)
   endtask : rc
   // one-cycle event pulse, outputs checked at the falling edge after
   task automatic ev(input logic [16:0] v, input logic s);
      @(posedge hclk);
      {fd, sr, to, pt} <= v; calc_strobe <= s;
      @(posedge hclk);
      {fd, sr, to, pt} <= 17'h0; calc_strobe <= 1'b0;
      @(negedge hclk);
   endtask : ev
   task t_ref;
      wr(FAULT_EN_OFS, 32'h400); wr(IRQ_MASK_OFS, 32'h7);
      wr(GROUP_SEL_OFS, {16'h0, CODE_SPD_REF});
      p1 <= 32'sd36864; p7 <= -32'sd40000; ts <= 32'sd40000; tq <= -32'sd99999;
      ev(17'h0, 1'b1);
      `chk("fault", 1'b1, fault_out)
      `chk("ref1", 16'sh7fff, o1)
      `chk("ref7", 16'sh8001, o7)
      `chk("trim", 16'sh7fff, ot)
      `chk("torq", 16'sh8001, oq)
      rc(FLAG_WORD_OFS, 32'h109);
      `chk("irq", 1'b1, irq)
      rc(REPORT_CODE_OFS, 32'h0bf2);
      rc(IRQ_STATUS_OFS, 32'h5);
      rc(IRQ_STATUS_OFS, 32'h0);
      `chk("irq", 1'b0, irq)
      p1 <= -32'sd36864; p7 <= 32'sd40000; ts <= -32'sd40000;
      ev(17'h0, 1'b1);
      rc(FLAG_WORD_OFS, 32'h30f);
   endtask : t_ref
   task automatic t_groups;
      logic [15:0] c[4] = '{CODE_FDBK, CODE_SPD_REG, CODE_TORQUE, CODE_PTRIM};
      logic [16:0] v[4] = '{17'h1c000, 17'h03f00, 17'h000f0, 17'h0000f};
      logic [31:0] e[4] = '{32'h7, 32'h30f, 32'h7400, 32'hf};
      for (int i = 0; i < 4; i++) begin
         wr(GROUP_SEL_OFS, {16'h0, c[i]});
         ev(v[i], 1'b0);
         rc(FLAG_WORD_OFS, e[i]);
      end
      wr(GROUP_SEL_OFS, 32'h1234);
      rc(FLAG_WORD_OFS, 32'h0);
      @(posedge hclk) fclr <= 1'b1;
      @(posedge hclk) fclr <= 1'b0;
      wr(GROUP_SEL_OFS, {16'h0, CODE_SPD_REG});
      rc(FLAG_WORD_OFS, 32'h0);
      `chk("fault", 1'b0, fault_out)
   endtask : t_groups
   task t_report;
      wr(FAULT_EN_OFS, 32'h0); wr(WARN_EN_OFS, 32'h400);
      ev(17'h0, 1'b1);
      `chk("warn", 1'b1, warn_out)
      `chk("fault", 1'b0, fault_out)
      rc(REPORT_CODE_OFS, 32'h0c12);
      wr(FAULT_CLEAR_OFS, 32'h1);
      // the clear lands at the edge that ends the write; look after it
      @(negedge hclk);
      `chk("warn", 1'b0, warn_out)
      wr(WARN_EN_OFS, 32'h0); wr(IRQ_MASK_OFS, 32'h0);
      bus(IRQ_STATUS_OFS, 1'b0, 32'h0);
      ev(17'h0, 1'b1);
      `chk("rep", 2'h0, {fault_out, warn_out})
      rc(IRQ_STATUS_OFS, 32'h4);
      `chk("irq", 1'b0, irq)
      // tighter torque limit, bit 15 of the write is dropped
      wr(TORQUE_LIM_OFS, 32'h9000);
      rc(TORQUE_LIM_OFS, 32'h1000);
      p1 <= 32'sd1234;
      p7 <= -32'sd1234;
      tq <= 32'sd20000;
      ev(17'h0, 1'b1);
      `chk("ref1", 16'sh04d2, o1)
      `chk("ref7", 16'shfb2e, o7)
      `chk("torq", 16'sh1000, oq)
   endtask : t_report
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rc(TORQUE_LIM_OFS, 32'h7fff);
      rc(FLAG_WORD_OFS, 32'h0);
      t_ref;
      t_groups;
      t_report;
      summarize;
   end
endmodule : tb_top
`default_nettype wire
